// File: rtl/ctm_consts.vh
/*
 * Constants for the control timer: register selectors, field positions,
 * waveform modes, interrupt flag positions and reset values.
 * Assumes inclusion by bare name from rtl/ design files.
 */
`ifndef CTM_CONSTS_VH
`define CTM_CONSTS_VH

`define CTM_CNT_W 16
`define CTM_NCH 4
`define CTM_PER_RST 16'hFFFF
`define CTM_CC_RST 16'h0000

// Write selectors
`define CTM_SEL_CTRL 4'h0
`define CTM_SEL_PER 4'h1
`define CTM_SEL_CC0 4'h2
`define CTM_SEL_CC1 4'h3
`define CTM_SEL_CC2 4'h4
`define CTM_SEL_CC3 4'h5
`define CTM_SEL_WAVE 4'h6
`define CTM_SEL_PATTERN_VALUE 4'h7
`define CTM_SEL_DTI 4'h8
`define CTM_SEL_FCLR 4'h9
`define CTM_SEL_IEN 4'hA
`define CTM_SEL_CNT 4'hB

// Control word fields
`define CTM_CTRL_EN 0
`define CTM_CTRL_EVCNT 1
`define CTM_CTRL_DIR 2
`define CTM_CTRL_DBGRUN 3
`define CTM_CTRL_DBGFLT 4
`define CTM_CTRL_CIRC 5
`define CTM_CTRL_CPT_LSB 8
`define CTM_CTRL_PSC_LSB 12

// Waveform word fields
`define CTM_WAVE_MODE_LSB 0
`define CTM_WAVE_SWAP_LSB 4
`define CTM_WAVE_OTMX_LSB 8

// Waveform modes
`define CTM_MODE_NFRQ 2'h0
`define CTM_MODE_MFRQ 2'h1
`define CTM_MODE_NPWM 2'h2
`define CTM_MODE_DSPWM 2'h3

// Interrupt flag positions
`define CTM_IF_OVF 0
`define CTM_IF_TRG 1
`define CTM_IF_FLT 2
`define CTM_IF_MC_LSB 4
`define CTM_IF_W 8

`define CTM_DT_W 8

`endif

// File: rtl/ctm_sync.v
/*
 * Handshake crossing of a written word from the register bus clock domain
 * into the count clock domain.
 * Assumes both clocks run; sender waits for busy low before a new word.
 */
`timescale 1ns/100ps
module ctm_sync #(
	parameter W = 32
) (
	// Source domain
	input wire src_clk,
	input wire src_reset,
	input wire src_req,
	input wire [W-1:0] src_data,
	output wire src_busy,
	// Destination domain
	input wire dst_clk,
	input wire dst_reset,
	output reg dst_pulse,
	output reg [W-1:0] dst_data
);
	reg req_tgl_ff;
	reg [W-1:0] hold_ff;
	reg [2:0] dsync_ff;
	reg [1:0] async_ff;

	always @(posedge src_clk) begin
		if (src_reset) begin
			req_tgl_ff <= 1'b0;
			hold_ff <= {W{1'b0}};
			async_ff <= 2'b00;
		end else begin
			async_ff <= {async_ff[0], dsync_ff[2]};
			if (src_req && !src_busy) begin
				req_tgl_ff <= ~req_tgl_ff;
				hold_ff <= src_data;
			end
		end
	end

	assign src_busy = req_tgl_ff ^ async_ff[1];

	always @(posedge dst_clk) begin
		if (dst_reset) begin
			dsync_ff <= 3'b000;
			dst_pulse <= 1'b0;
			dst_data <= {W{1'b0}};
		end else begin
			dsync_ff <= {dsync_ff[1:0], req_tgl_ff};
			dst_pulse <= dsync_ff[2] ^ dsync_ff[1];
			if (dsync_ff[2] ^ dsync_ff[1])
				dst_data <= hold_ff;
		end
	end
endmodule

// File: rtl/ctm_dti.v
/*
 * Dead-time insertion for one output pair: low side follows the waveform,
 * high side its inverse, each rising edge delayed by a dead-time count.
 * Assumes a waveform input on the count clock.
 */
`timescale 1ns/100ps
module ctm_dti #(
	parameter DW = 8
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Waveform and settings
	input wire wave_in,
	input wire [DW-1:0] dt_ls,
	input wire [DW-1:0] dt_hs,
	// Outputs
	output reg ls_out,
	output reg hs_out
);
	reg [DW-1:0] cnt_ff;
	reg prev_ff;

	always @(posedge clk) begin
		if (reset) begin
			cnt_ff <= {DW{1'b0}};
			prev_ff <= 1'b0;
			ls_out <= 1'b0;
			hs_out <= 1'b0;
		end else begin
			prev_ff <= wave_in;
			if (wave_in != prev_ff) begin
				// Both sides off during the gap
				ls_out <= 1'b0;
				hs_out <= 1'b0;
				cnt_ff <= wave_in ? dt_ls : dt_hs;
			end else if (cnt_ff != {DW{1'b0}}) begin
				cnt_ff <= cnt_ff - {{(DW-1){1'b0}}, 1'b1};
			end else begin
				ls_out <= wave_in;
				hs_out <= ~wave_in;
			end
		end
	end
endmodule

// File: rtl/ctm_timer.v
/*
 * Control timer core: counter, four compare/capture channels, waveform
 * modes, output matrix, dead-time, swap, pattern, dither, faults, flags.
 * Assumes a register bus clock for writes and a free running count clock;
 * event inputs are asynchronous and are synchronized here.
 */
`timescale 1ns/100ps
`include "ctm_consts.vh"
module ctm_timer #(
	parameter CW = `CTM_CNT_W,
	parameter NCH = `CTM_NCH
) (
	// Register bus side
	input wire register_bus_clock,
	input wire bus_reset,
	input wire wr_en,
	input wire [3:0] wr_sel,
	input wire [31:0] wr_data,
	input wire wr_from_debugger,
	input wire protect_en,
	output wire wr_busy,
	output reg wr_refused_ff,
	// Count domain
	input wire count_clock,
	input wire reset,
	input wire cpu_debug_halt,
	input wire [1:0] counter_input_event,
	input wire [NCH-1:0] channel_input_event,
	input wire [1:0] recoverable_fault,
	input wire [1:0] nonrecoverable_fault,
	// Outputs
	output wire [2*NCH-1:0] waveform_output,
	output reg [CW-1:0] count_ff,
	output reg [`CTM_IF_W-1:0] interrupt_flags_ff,
	output wire irq,
	output reg dma_req_ff,
	output reg ev_count_ff,
	output reg ev_retrig_ff,
	output reg ev_ovf_ff,
	output reg [NCH-1:0] ev_ch_ff,
	output reg [CW*NCH-1:0] capture_value_ff
);
	wire w_pulse;
	wire [35:0] w_word;
	// Channel index of selectors 2 to 5, kept two bits wide
	wire [1:0] w_ch = w_word[33:32] - 2'd2;
	reg prot_ok;
	reg [1:0] ev_s1_ff, ev_s2_ff, ev_s3_ff;
	reg [NCH-1:0] mc_s1_ff, mc_s2_ff, mc_s3_ff;
	reg [1:0] rf_s1_ff, rf_s2_ff, nf_s1_ff, nf_s2_ff;
	reg dbg_s1_ff, dbg_s2_ff;
	reg [15:0] ctrl_ff;
	reg [CW-1:0] period_value_ff, period_buffer_ff;
	reg [CW*NCH-1:0] cc_ff, channel_value_buffer_ff;
	reg [15:0] wave_ff, waveform_control_buffer_ff;
	reg [15:0] pattern_value_ff, pattern_value_buffer_ff;
	reg [2*`CTM_DT_W-1:0] dti_ff;
	reg [`CTM_IF_W-1:0] ien_ff;
	reg [NCH:0] bufv_ff;
	reg buf_wave_ff, buf_pattern_value_ff;
	reg [3:0] psc_cnt_ff;
	reg down_ff;
	reg nrf_latch_ff;
	reg [4:0] dith_ff;
	reg [NCH-1:0] cmp_ff;
	wire [3:0] psc_sel;
	wire running, tick, at_top, at_zero, update;
	wire [1:0] mode;
	wire [CW-1:0] top;
	wire [NCH-1:0] raw_wave, routed;
	wire [2*NCH-1:0] dti_out;
	wire fault_rec, fault_nrec;
	reg [`CTM_IF_W-1:0] if_set;
	reg [2*NCH-1:0] swapped;
	integer i;

	function [CW-1:0] ch_val;
		input [CW*NCH-1:0] vec;
		input integer idx;
		begin
			ch_val = vec[idx*CW +: CW];
		end
	endfunction

	function fault_nrec_set;
		input [1:0] src;
		input dbg;
		begin
			fault_nrec_set = (|src) || dbg;
		end
	endfunction

	// Protected writes refused unless exempt or issued by the debugger
	always @* begin
		case (wr_sel)
			`CTM_SEL_PER, `CTM_SEL_CC0, `CTM_SEL_CC1, `CTM_SEL_CC2, `CTM_SEL_CC3,
			`CTM_SEL_WAVE, `CTM_SEL_PATTERN_VALUE, `CTM_SEL_FCLR: prot_ok = 1'b1;
			default: prot_ok = !protect_en || wr_from_debugger;
		endcase
	end

	always @(posedge register_bus_clock) begin
		if (bus_reset)
			wr_refused_ff <= 1'b0;
		else
			wr_refused_ff <= wr_en && !prot_ok;
	end

	ctm_sync #(
		.W(36)
	) u_sync (
		.src_clk(register_bus_clock),
		.src_reset(bus_reset),
		.src_req(wr_en && prot_ok),
		.src_data({wr_sel, wr_data}),
		.src_busy(wr_busy),
		.dst_clk(count_clock),
		.dst_reset(reset),
		.dst_pulse(w_pulse),
		.dst_data(w_word)
	);

	// Two-stage synchronizers, third stage for edge detection
	always @(posedge count_clock) begin
		if (reset) begin
			ev_s1_ff <= 2'b00;
			ev_s2_ff <= 2'b00;
			ev_s3_ff <= 2'b00;
			mc_s1_ff <= {NCH{1'b0}};
			mc_s2_ff <= {NCH{1'b0}};
			mc_s3_ff <= {NCH{1'b0}};
			rf_s1_ff <= 2'b00;
			rf_s2_ff <= 2'b00;
			nf_s1_ff <= 2'b00;
			nf_s2_ff <= 2'b00;
			dbg_s1_ff <= 1'b0;
			dbg_s2_ff <= 1'b0;
		end else begin
			ev_s1_ff <= counter_input_event;
			ev_s2_ff <= ev_s1_ff;
			ev_s3_ff <= ev_s2_ff;
			mc_s1_ff <= channel_input_event;
			mc_s2_ff <= mc_s1_ff;
			mc_s3_ff <= mc_s2_ff;
			rf_s1_ff <= recoverable_fault;
			rf_s2_ff <= rf_s1_ff;
			nf_s1_ff <= nonrecoverable_fault;
			nf_s2_ff <= nf_s1_ff;
			dbg_s1_ff <= cpu_debug_halt;
			dbg_s2_ff <= dbg_s1_ff;
		end
	end

	wire [1:0] ev_rise = ev_s2_ff & ~ev_s3_ff;
	wire [NCH-1:0] mc_rise = mc_s2_ff & ~mc_s3_ff;

	assign psc_sel = ctrl_ff[`CTM_CTRL_PSC_LSB +: 4];
	assign mode = wave_ff[`CTM_WAVE_MODE_LSB +: 2];
	// Halted by debugger unless run in debug is set
	assign running = ctrl_ff[`CTM_CTRL_EN] && !(dbg_s2_ff && !ctrl_ff[`CTM_CTRL_DBGRUN]);
	assign tick = running && (ctrl_ff[`CTM_CTRL_EVCNT] ? ev_rise[0] : (psc_cnt_ff == psc_sel));
	assign top = (mode == `CTM_MODE_MFRQ) ? ch_val(cc_ff, 0) : period_value_ff;
	assign at_top = (count_ff == top);
	assign at_zero = (count_ff == {CW{1'b0}});
	assign update = tick && ((mode == `CTM_MODE_DSPWM) ? (at_top || at_zero) :
		(ctrl_ff[`CTM_CTRL_DIR] ? at_zero : at_top));
	assign fault_rec = |rf_s2_ff;
	assign fault_nrec = nrf_latch_ff;

	always @(posedge count_clock) begin
		if (reset) begin
			ctrl_ff <= 16'h0000;
			period_value_ff <= `CTM_PER_RST;
			period_buffer_ff <= `CTM_PER_RST;
			cc_ff <= {NCH{`CTM_CC_RST}};
			channel_value_buffer_ff <= {NCH{`CTM_CC_RST}};
			wave_ff <= 16'h0000;
			waveform_control_buffer_ff <= 16'h0000;
			pattern_value_ff <= 16'h0000;
			pattern_value_buffer_ff <= 16'h0000;
			dti_ff <= {(2*`CTM_DT_W){1'b0}};
			ien_ff <= {`CTM_IF_W{1'b0}};
			bufv_ff <= {(NCH+1){1'b0}};
			buf_wave_ff <= 1'b0;
			buf_pattern_value_ff <= 1'b0;
			psc_cnt_ff <= 4'h0;
			count_ff <= {CW{1'b0}};
			down_ff <= 1'b0;
			nrf_latch_ff <= 1'b0;
			dith_ff <= 5'h00;
			interrupt_flags_ff <= {`CTM_IF_W{1'b0}};
			capture_value_ff <= {(CW*NCH){1'b0}};
			dma_req_ff <= 1'b0;
			ev_count_ff <= 1'b0;
			ev_retrig_ff <= 1'b0;
			ev_ovf_ff <= 1'b0;
			ev_ch_ff <= {NCH{1'b0}};
		end else begin
			// Synchronized writes land in control, buffer and counter registers
			if (w_pulse) begin
				case (w_word[35:32])
					`CTM_SEL_CTRL: ctrl_ff <= w_word[15:0];
					`CTM_SEL_PER: begin
						period_buffer_ff <= w_word[CW-1:0];
						bufv_ff[NCH] <= 1'b1;
					end
					`CTM_SEL_CC0, `CTM_SEL_CC1, `CTM_SEL_CC2, `CTM_SEL_CC3: begin
						channel_value_buffer_ff[w_ch*CW +: CW] <= w_word[CW-1:0];
						bufv_ff[w_ch] <= 1'b1;
					end
					`CTM_SEL_WAVE: begin
						waveform_control_buffer_ff <= w_word[15:0];
						buf_wave_ff <= 1'b1;
					end
					`CTM_SEL_PATTERN_VALUE: begin
						pattern_value_buffer_ff <= w_word[15:0];
						buf_pattern_value_ff <= 1'b1;
					end
					`CTM_SEL_DTI: dti_ff <= w_word[2*`CTM_DT_W-1:0];
					`CTM_SEL_IEN: ien_ff <= w_word[`CTM_IF_W-1:0];
					`CTM_SEL_CNT: count_ff <= w_word[CW-1:0];
					default: ;
				endcase
			end
			psc_cnt_ff <= (!running || psc_cnt_ff == psc_sel) ? 4'h0 : psc_cnt_ff + 4'h1;
			if (fault_nrec_set(nf_s2_ff, dbg_s2_ff && ctrl_ff[`CTM_CTRL_DBGFLT]))
				nrf_latch_ff <= 1'b1;
			else if (w_pulse && w_word[35:32] == `CTM_SEL_CTRL && !w_word[`CTM_CTRL_EN])
				nrf_latch_ff <= 1'b0;
			// Re-trigger on the second counter event restarts the count
			if (running && ev_rise[1]) begin
				count_ff <= ctrl_ff[`CTM_CTRL_DIR] ? top : {CW{1'b0}};
			end else if (tick && !(w_pulse && w_word[35:32] == `CTM_SEL_CNT)) begin
				if (mode == `CTM_MODE_DSPWM) begin
					if (at_top) down_ff <= 1'b1;
					else if (at_zero) down_ff <= 1'b0;
					count_ff <= (down_ff && !at_zero) || at_top ? count_ff - 1'b1 : count_ff + 1'b1;
				end else if (ctrl_ff[`CTM_CTRL_DIR])
					count_ff <= at_zero ? top : count_ff - 1'b1;
				else
					count_ff <= at_top ? {CW{1'b0}} : count_ff + 1'b1;
			end
			// Buffers move on update; circular mode swaps live and buffer period and channel values
			if (update) begin
				dith_ff <= dith_ff + 5'h01;
				if (bufv_ff[NCH] || ctrl_ff[`CTM_CTRL_CIRC]) begin
					period_value_ff <= period_buffer_ff;
					if (ctrl_ff[`CTM_CTRL_CIRC]) period_buffer_ff <= period_value_ff;
				end
				for (i = 0; i < NCH; i = i + 1) begin
					if (bufv_ff[i] || ctrl_ff[`CTM_CTRL_CIRC]) begin
						cc_ff[i*CW +: CW] <= ch_val(channel_value_buffer_ff, i);
						if (ctrl_ff[`CTM_CTRL_CIRC])
							channel_value_buffer_ff[i*CW +: CW] <= ch_val(cc_ff, i);
					end
				end
				bufv_ff <= {(NCH+1){1'b0}};
				if (buf_wave_ff) wave_ff <= waveform_control_buffer_ff;
				if (buf_pattern_value_ff) pattern_value_ff <= pattern_value_buffer_ff;
				buf_wave_ff <= 1'b0;
				buf_pattern_value_ff <= 1'b0;
			end
			// Captures timestamp channel events
			for (i = 0; i < NCH; i = i + 1)
				if (ctrl_ff[`CTM_CTRL_CPT_LSB+i] && mc_rise[i])
					capture_value_ff[i*CW +: CW] <= count_ff;
			ev_count_ff <= tick;
			ev_retrig_ff <= running && ev_rise[1];
			ev_ovf_ff <= update;
			ev_ch_ff <= if_set[`CTM_IF_MC_LSB +: NCH];
			dma_req_ff <= update;
			// Set wins over clear
			interrupt_flags_ff <= (interrupt_flags_ff &
				~((w_pulse && w_word[35:32] == `CTM_SEL_FCLR) ? w_word[`CTM_IF_W-1:0] :
				{`CTM_IF_W{1'b0}})) | if_set;
		end
	end

	// Compare outputs per channel
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_ch
			wire [CW-1:0] cv = ch_val(cc_ff, g);
			// Dither adds one count on some cycles for channel zero
			wire [CW:0] cvd = {1'b0, cv} + {{CW{1'b0}}, (g == 0 && dith_ff < cv[4:0])};
			assign raw_wave[g] = (mode == `CTM_MODE_NFRQ || mode == `CTM_MODE_MFRQ) ?
				cmp_ff[g] : ({1'b0, count_ff} < cvd);
		end
	endgenerate

	always @(posedge count_clock) begin
		if (reset)
			cmp_ff <= {NCH{1'b0}};
		else
			for (i = 0; i < NCH; i = i + 1)
				if (update) cmp_ff[i] <= ~cmp_ff[i];
	end

	always @* begin
		if_set = {`CTM_IF_W{1'b0}};
		if_set[`CTM_IF_OVF] = update;
		if_set[`CTM_IF_TRG] = running && ev_rise[1];
		if_set[`CTM_IF_FLT] = fault_rec ||
			fault_nrec_set(nf_s2_ff, dbg_s2_ff && ctrl_ff[`CTM_CTRL_DBGFLT]);
		for (i = 0; i < NCH; i = i + 1)
			if_set[`CTM_IF_MC_LSB+i] = ctrl_ff[`CTM_CTRL_CPT_LSB+i] ? mc_rise[i] :
				(tick && count_ff == ch_val(cc_ff, i));
	end

	assign irq = |(interrupt_flags_ff & ien_ff);

	// Output matrix: either straight or channel zero on all pins
	assign routed = wave_ff[`CTM_WAVE_OTMX_LSB] ? {NCH{raw_wave[0]}} : raw_wave;

	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_dti
			ctm_dti #(
				.DW(`CTM_DT_W)
			) u_dti (
				.clk(count_clock),
				.reset(reset),
				.wave_in(routed[g]),
				.dt_ls(dti_ff[`CTM_DT_W-1:0]),
				.dt_hs(dti_ff[2*`CTM_DT_W-1:`CTM_DT_W]),
				.ls_out(dti_out[g]),
				.hs_out(dti_out[g+NCH])
			);
		end
	endgenerate

	always @* begin
		swapped = dti_out;
		for (i = 0; i < NCH; i = i + 1)
			if (wave_ff[`CTM_WAVE_SWAP_LSB+i]) begin
				swapped[i] = dti_out[i+NCH];
				swapped[i+NCH] = dti_out[i];
			end
	end

	// Pattern forces level where enabled; faults force outputs low
	generate
		for (g = 0; g < 2*NCH; g = g + 1) begin : g_out
			reg wo_ff;
			always @(posedge count_clock) begin
				if (reset)
					wo_ff <= 1'b0;
				else if (fault_nrec || fault_rec)
					wo_ff <= 1'b0;
				else if (pattern_value_ff[g])
					wo_ff <= pattern_value_ff[g+8];
				else
					wo_ff <= swapped[g];
			end
			assign waveform_output[g] = wo_ff;
		end
	endgenerate
endmodule

// File: sim/ctm_power_stage.sv
/* Power stage model on the waveform pins.
   Assumes low sides on [3:0], high sides on [7:4]. */
`timescale 1ns/100ps
module ctm_power_stage (
	// Clock and reset
	input wire clk,
	input wire reset,
	// Gate drive
	input wire [7:0] gate,
	// Observations
	output reg shoot_ff,
	output reg [7:0] seen_ff
);
	always @(posedge clk) begin
		if (reset) begin
			shoot_ff <= 1'b0;
			seen_ff <= 8'h00;
		end else begin
			shoot_ff <= shoot_ff | (|(gate[3:0] & gate[7:4]));
			seen_ff <= seen_ff | gate;
		end
	end
endmodule

// File: sim/ctm_timer_assertions.sv
/* Port checks on the control timer in both clock domains.
   Assumes binding to every ctm_timer instance. */
`timescale 1ns/100ps
`include "ctm_consts.vh"
module ctm_timer_chk #(
	parameter NCH = 4
) (
	// Bus domain
	input wire register_bus_clock,
	input wire bus_reset,
	input wire wr_en,
	input wire [3:0] wr_sel,
	input wire wr_from_debugger,
	input wire protect_en,
	input wire wr_busy,
	input wire wr_refused_ff,
	// Count domain
	input wire count_clock,
	input wire reset,
	input wire [2*NCH-1:0] waveform_output,
	input wire [`CTM_IF_W-1:0] interrupt_flags_ff,
	input wire irq,
	input wire ev_ovf_ff,
	input wire [NCH-1:0] ev_ch_ff
);
	property p_busy_cause; @(posedge register_bus_clock) disable iff (bus_reset)
		$rose(wr_busy) |-> $past(wr_en); endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without write");
	property p_refuse; @(posedge register_bus_clock) disable iff (bus_reset)
		wr_en && !wr_busy && protect_en && !wr_from_debugger && wr_sel == 4'h0 |=> wr_refused_ff;
	endproperty
	a_refuse: assert property (p_refuse) else $error("protected write taken");
	property p_exempt; @(posedge register_bus_clock) disable iff (bus_reset)
		wr_en && protect_en && (wr_sel inside {[4'h1:4'h7], 4'h9}) |=> !wr_refused_ff; endproperty
	a_exempt: assert property (p_exempt) else $error("exempt write refused");
	property p_debugger; @(posedge register_bus_clock) disable iff (bus_reset)
		wr_en && wr_from_debugger |=> !wr_refused_ff; endproperty
	a_debugger: assert property (p_debugger) else $error("debugger write refused");
	property p_irq_cause; @(posedge count_clock) disable iff (reset)
		irq |-> |interrupt_flags_ff; endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without flag");
	property p_ovf_flag; @(posedge count_clock) disable iff (reset)
		ev_ovf_ff |-> ##[0:2] interrupt_flags_ff[`CTM_IF_OVF]; endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag missing");
	property p_ch_flag; @(posedge count_clock) disable iff (reset)
		|ev_ch_ff |-> ##[0:2] |interrupt_flags_ff[7:4]; endproperty
	a_ch_flag: assert property (p_ch_flag) else $error("channel flag missing");
	property p_no_overlap; @(posedge count_clock) disable iff (reset)
		(waveform_output[NCH-1:0] & waveform_output[2*NCH-1:NCH]) == {NCH{1'b0}}; endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("both sides on");
	c_ovf: cover property (@(posedge count_clock) ev_ovf_ff);
	c_refused: cover property (@(posedge register_bus_clock) wr_refused_ff);
	c_capture: cover property (@(posedge count_clock) |ev_ch_ff);
endmodule
bind ctm_timer ctm_timer_chk #(.NCH(NCH)) i_chk (
	.register_bus_clock(register_bus_clock), .bus_reset(bus_reset), .wr_en(wr_en),
	.wr_sel(wr_sel), .wr_from_debugger(wr_from_debugger), .protect_en(protect_en),
	.wr_busy(wr_busy), .wr_refused_ff(wr_refused_ff), .count_clock(count_clock),
	.reset(reset), .waveform_output(waveform_output), .irq(irq),
	.interrupt_flags_ff(interrupt_flags_ff), .ev_ovf_ff(ev_ovf_ff), .ev_ch_ff(ev_ch_ff)
);

// File: sim/tb_control_timer_integration.sv
/* Self-checking bench for the control timer.
   Assumes one clock feeds both domains. */
`timescale 1ns/100ps
`include "ctm_consts.vh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_control_timer_integration;
	localparam [7:0] MTAB = 8'hB4;
	reg clk = 1'b0, rst = 1'b1, wr_en = 1'b0, dbg = 1'b0, prot = 1'b0, halt = 1'b0;
	reg [3:0] sel = 4'h0, chev = 4'h0, chseen = 4'h0;
	reg [31:0] dat = 32'h0, rs = 32'h80CA;
	reg [1:0] cev = 2'h0, nrf = 2'h0, rfl = 2'h0;
	reg [15:0] snap, cmax = 16'h0;
	reg [7:0] wprev = 8'h00;
	reg rseen = 1'b0, dseen = 1'b0, cseen = 1'b0, wchg = 1'b0;
	wire busy, refused, irq, dma, evc, evr, evo, shoot;
	wire [3:0] evch;
	wire [7:0] wo, flags, seen;
	wire [15:0] cnt;
	wire [63:0] capv;
	int fails = 0, n_tests = 0, cyc = 0, nref = 0, p, k, i, ovq[$];
	ctm_timer i_dut (
		.register_bus_clock(clk), .bus_reset(rst), .wr_en(wr_en), .wr_sel(sel),
		.wr_data(dat), .wr_from_debugger(dbg), .protect_en(prot), .wr_busy(busy),
		.wr_refused_ff(refused), .count_clock(clk), .reset(rst), .cpu_debug_halt(halt),
		.counter_input_event(cev), .channel_input_event(chev), .recoverable_fault(rfl),
		.nonrecoverable_fault(nrf), .waveform_output(wo), .count_ff(cnt),
		.interrupt_flags_ff(flags), .irq(irq), .dma_req_ff(dma), .ev_count_ff(evc),
		.ev_retrig_ff(evr), .ev_ovf_ff(evo), .ev_ch_ff(evch), .capture_value_ff(capv)
	);
	ctm_power_stage i_stage (.clk(clk), .reset(rst), .gate(wo), .shoot_ff(shoot), .seen_ff(seen));
	always #2 clk = ~clk;
	always @(negedge clk) begin
		cyc++;
		if (refused === 1'b1) nref++;
		if (evo === 1'b1) ovq.push_back(cyc);
		if (cnt > cmax) cmax = cnt;
		if (wo !== wprev) wchg = 1'b1;
		wprev = wo;
		chseen = chseen | evch;
		rseen = rseen | evr;
		dseen = dseen | dma;
		cseen = cseen | evc;
	end
	function [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task wr(input [3:0] s, input [31:0] d);
		int n;
		@(negedge clk);
		wr_en = 1'b1;
		sel = s;
		dat = d;
		@(negedge clk);
		wr_en = 1'b0;
		for (n = 0; n < 64 && busy !== 1'b0; n++) @(negedge clk);
		@(negedge clk);
	endtask
	task summarize();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		tick(12);
		rst = 1'b0;
		tick(1);
		`CHK("count", 16'h0000, cnt)
		`CHK("flags", 8'h00, flags)
		p = 8 + rnd() % 32;
		wr(`CTM_SEL_PER, p);
		wr(`CTM_SEL_CC0, p / 2);
		wr(`CTM_SEL_DTI, ((rnd() % 4) << 8) | (rnd() % 4));
		wr(`CTM_SEL_CNT, 32'hFFFC);
		wr(`CTM_SEL_CTRL, 32'h1);
		for (i = 0; i < 4; i++) begin
			k = MTAB[2 * i +: 2];
			wr(`CTM_SEL_WAVE, k);
			tick(p + 4);
			cmax = 16'h0;
			tick(2 * p + 6);
			`CHK("top", (k == 1) ? p / 2 : p, cmax)
		end
		`CHK("period", p + 1, ovq[$] - ovq[$ - 1])
		`CHK("ovf flag", 1'b1, flags[`CTM_IF_OVF])
		`CHK("gates", 2'b11, {seen[4], seen[0]})
		`CHK("dma", 1'b1, dseen)
		wr(`CTM_SEL_IEN, 32'h2);
		wr(`CTM_SEL_FCLR, 32'hFF);
		cev = 2'h2;
		tick(4);
		cev = 2'h0;
		tick(6);
		`CHK("trg flag", 1'b1, flags[`CTM_IF_TRG])
		`CHK("irq on", 1'b1, irq)
		`CHK("trg event", 1'b1, rseen)
		wr(`CTM_SEL_IEN, 32'h0);
		`CHK("irq off", 1'b0, irq)
		`CHK("sticky", 1'b1, flags[`CTM_IF_TRG])
		wr(`CTM_SEL_FCLR, 32'h2);
		`CHK("trg clear", 1'b0, flags[`CTM_IF_TRG])
		prot = 1'b1;
		nref = 0;
		wr(`CTM_SEL_CTRL, 32'h0);
		snap = cnt;
		tick(3);
		`CHK("refused", 1, nref)
		`CHK("running", 1'b1, cnt !== snap)
		wr(`CTM_SEL_PER, p);
		`CHK("exempt", 1, nref)
		dbg = 1'b1;
		wr(`CTM_SEL_CTRL, 32'h0);
		dbg = 1'b0;
		prot = 1'b0;
		snap = cnt;
		tick(5);
		`CHK("dbg write", 1, nref)
		`CHK("stopped", snap, cnt)
		wr(`CTM_SEL_CNT, 32'h0);
		wr(`CTM_SEL_FCLR, 32'hFF);
		wr(`CTM_SEL_CTRL, 32'h0F03);
		chseen = 4'h0;
		k = 1 + rnd() % 7;
		for (i = 0; i < k; i++) begin
			cev = 2'h1;
			tick(3);
			cev = 2'h0;
			tick(3);
		end
		tick(6);
		`CHK("events", k, cnt)
		chev = 4'hF;
		tick(3);
		chev = 4'h0;
		tick(6);
		for (i = 0; i < 4; i++) `CHK("capture", k, capv[16 * i +: 16])
		`CHK("ch flags", 4'hF, flags[7:4])
		`CHK("ch events", 4'hF, chseen)
		`CHK("cnt event", 1'b1, cseen)
		wr(`CTM_SEL_CTRL, 32'h1);
		halt = 1'b1;
		tick(6);
		snap = cnt;
		tick(20);
		`CHK("halted", snap, cnt)
		wr(`CTM_SEL_CTRL, 32'h9);
		snap = cnt;
		tick(4);
		`CHK("dbg run", 1'b1, cnt !== snap)
		wr(`CTM_SEL_FCLR, 32'hFF);
		wr(`CTM_SEL_CTRL, 32'h19);
		tick(6);
		`CHK("dbg fault", 1'b1, flags[`CTM_IF_FLT])
		halt = 1'b0;
		wr(`CTM_SEL_CTRL, 32'h0);
		wr(`CTM_SEL_FCLR, 32'hFF);
		wr(`CTM_SEL_CTRL, 32'h1);
		rfl = 2'h1 << (rnd() % 2);
		tick(4);
		`CHK("rec fault out", 8'h00, wo)
		`CHK("rec fault flag", 1'b1, flags[`CTM_IF_FLT])
		rfl = 2'h0;
		tick(4);
		wr(`CTM_SEL_FCLR, 32'hFF);
		`CHK("rec released", 1'b0, flags[`CTM_IF_FLT])
		wchg = 1'b0;
		tick(2 * p + 2);
		`CHK("rec resume", 1'b1, wchg)
		nrf = 2'h2;
		tick(4);
		nrf = 2'h0;
		tick(6);
		`CHK("fault flag", 1'b1, flags[`CTM_IF_FLT])
		wchg = 1'b0;
		tick(2 * p + 2);
		`CHK("frozen", 1'b0, wchg)
		`CHK("overlap", 1'b0, shoot)
		// Down counting on every second clock, channel two beyond top
		wr(`CTM_SEL_CTRL, 32'h0);
		wr(`CTM_SEL_CC2, 32'hFFF0);
		wr(`CTM_SEL_CTRL, 32'h1005);
		tick(4 * p + 12);
		`CHK("prescaled", 2 * (p + 1), ovq[$] - ovq[$ - 1])
		wr(`CTM_SEL_FCLR, 32'hFF);
		tick(2 * p + 6);
		`CHK("ch match", 4'hB, flags[7:4])
		wr(`CTM_SEL_PATTERN_VALUE, 32'h0FFF);
		tick(2 * p + 6);
		`CHK("pattern", 8'h0F, wo)
		summarize();
	end
	initial begin
		#(30000 * 4);
		fails++;
		summarize();
	end
endmodule
